// ---- include/scb_params.svh ----
// register indices, field positions, reset values and constants of the control bank
`ifndef SCB_PARAMS_SVH
`define SCB_PARAMS_SVH
// register indices; byte address is four times the index
`define SCB_IDX_SUPPLY 10'h0A7
`define SCB_IDX_IEM 10'h0A8
`define SCB_IDX_IEX 10'h0A9
`define SCB_IDX_ROSC 10'h0AF
`define SCB_IDX_PORT3 10'h0B0
`define SCB_IDX_LCD 10'h0B1
// writable bit masks
`define SCB_MASK_SUPPLY 8'h7F
`define SCB_MASK_IEM 8'hBF
`define SCB_MASK_IEX 8'h07
`define SCB_MASK_ROSC 8'h1F
`define SCB_MASK_PORT3 8'hFF
`define SCB_MASK_LCD 8'hFF
// reset values
`define SCB_RST_SUPPLY 8'h22
`define SCB_RST_IEM 8'h00
`define SCB_RST_IEX 8'h00
`define SCB_RST_ROSC 8'h0C
`define SCB_RST_PORT3 8'hFF
`define SCB_RST_LCD 8'h2F
// supply level control fields
`define SCB_SAVE_BIT 6
`define SCB_RUN_LSB 3
`define SCB_SLEEP_LSB 0
// main interrupt enable fields
`define SCB_GATE_BIT 7
`define SCB_T2_BIT 5
`define SCB_UART_BIT 4
`define SCB_T1_BIT 3
`define SCB_EX1_BIT 2
`define SCB_T0_BIT 1
`define SCB_EX0_BIT 0
// extended interrupt enable fields
`define SCB_EX2_BIT 2
`define SCB_P1_BIT 1
`define SCB_T3_BIT 0
// resistor oscillator control fields
`define SCB_SRC_BIT 4
`define SCB_PSC_LSB 2
`define SCB_CHAN_LSB 0
// lcd control fields
`define SCB_DISP_BIT 7
`define SCB_LCD_CLOCK_SOURCE_BIT 6
`define SCB_FMR_LSB 4
`define SCB_DUTY_BIT 3
`define SCB_SEG_LSB 0
// supply ratio in 1/300 of the battery
`define SCB_RATIO_BASE 9'h073
`define SCB_RATIO_STEP 9'h00B
`define SCB_RATIO_FULL 9'h12C
// bus answers
`define SCB_RESP_OKAY 2'h0
`define SCB_RESP_SLVERR 2'h2
`endif

// ---- include/scb_pkg.sv ----
// types shared by the control bank files
package scb_pkg;
  typedef struct packed {
    logic timer3;
    logic port1;
    logic ext2;
    logic timer2;
    logic uart;
    logic timer1;
    logic ext1;
    logic timer0;
    logic ext0;
  } scb_irq_t;
  typedef struct packed {
    logic ext2;
    logic ext1;
    logic ext0;
  } scb_wake_t;
  typedef enum logic [1:0] {
    SCB_PSC_DIV64,
    SCB_PSC_DIV16,
    SCB_PSC_DIV4,
    SCB_PSC_DIV1
  } scb_psc_t;
endpackage

// ---- rtl/scb_prescaler.sv ----
// divider from the resistor oscillator tick down to the timer0 count tick
`timescale 1ns/1ps
`default_nettype none
module scb_prescaler
  import scb_pkg::*;
#(
  parameter int DIV_W = 6
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // oscillator tick and division select
  input wire logic rosc_tick_in,
  input wire scb_psc_t rosc_prescale_in,
  // divided tick
  output logic div_tick_out
);
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] limit;

  if (DIV_W < 6) begin : g_chk
    $error("scb_prescaler: DIV_W must be at least 6");
  end

  always_comb begin
    unique case (rosc_prescale_in)
      SCB_PSC_DIV64: limit = DIV_W'(63);
      SCB_PSC_DIV16: limit = DIV_W'(15);
      SCB_PSC_DIV4: limit = DIV_W'(3);
      SCB_PSC_DIV1: limit = '0;
    endcase
  end

  // a lowered divide while mid-count restarts at once rather than wrapping
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cnt_reg <= '0;
      div_tick_out <= 1'b0;
    end else if (rosc_tick_in && cnt_reg >= limit) begin
      cnt_reg <= '0;
      div_tick_out <= 1'b1;
    end else begin
      if (rosc_tick_in) begin
        cnt_reg <= cnt_reg + DIV_W'(1);
      end
      div_tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/scb_control_bank.sv ----
// control register bank: supply level, interrupt enables, oscillator, port3, lcd
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scb_params.svh"

// Summary of operation
// - with save on, run level code sets supply 115/300 to 192/300; resets 100
// - separate sleep level code for idle/stop, same encoding, resets to 010
// - main enable bit 7 blocks every interrupt when zero
// - main enable bit 5 allows timer2 interrupts, resets zero
// - main enable bit 4 allows uart interrupts, resets zero
// - main enable holds timer1 bit and timer0 bit 1
// - main enable bit 2 allows line 1 interrupt and stop wake-up
// - main enable bit 0 allows line 0 interrupt and stop wake-up
// - extended enable bit 2 allows line 2 interrupt and stop wake-up
// - extended enable bit 1 allows port1 pin-change interrupt, resets zero
// - extended enable bit 0 allows timer3 interrupts, resets zero
// - in counter mode, bit 4 picks timer0 pin or prescaled oscillator
// - bits 3:2 divide oscillator by 64, 16, 4 or 1; resets 11
// - bits 1:0 pick resistor pin a, b or c; resets 00
// - lcd bit 7 turns display drive on, resets off
// - lcd bits 5:4 pick frame rate, 3 highest; resets 10
// - lcd bit 3 picks 1/3 duty at 0, 1/4 duty at 1
// - lcd bits 2:0: code 0 all I/O, code c makes top c+1 port0 pins segments
module scb_control_bank
  import scb_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DIV_W = 6
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // power mode status
  input wire logic sleep_mode_in,
  input wire logic stop_mode_in,
  // interrupt requests in and gated requests out
  input wire scb_irq_t irq_req_in,
  output scb_irq_t irq_req_out,
  // external line levels and stop wake-up
  input wire scb_wake_t ext_line_active_in,
  output logic stop_wake_out,
  // timer0 count source
  input wire logic timer0_counter_mode_in,
  input wire logic timer0_pin_in,
  input wire logic rosc_tick_in,
  output logic timer0_count_tick_out,
  output logic [2:0] rosc_resistor_pin_out,
  // supply regulator
  output logic supply_save_select_out,
  output logic [8:0] vdd_ratio_num_out,
  // lcd controller
  output logic display_on_out,
  output logic lcd_clock_source_out,
  output logic [1:0] lcd_frame_rate_sel_out,
  output logic lcd_duty_select_out,
  output logic [7:0] port0_segment_mask_out,
  // port3 latch
  output logic [7:0] port3_data_out
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks and declarations
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk
    $error("scb_control_bank: ADDR_W must lie in 12..32");
  end

  typedef enum logic {SCB_WR_IDLE, SCB_WR_RESP} scb_wr_state_t;

  scb_wr_state_t wr_state_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [9:0] wr_idx_reg;
  logic [7:0] wr_data_reg;
  logic wr_lane_reg;
  logic [7:0] supply_reg;
  logic [7:0] iem_reg;
  logic [7:0] iex_reg;
  logic [7:0] rosc_reg;
  logic [7:0] port3_reg;
  logic [7:0] lcd_reg;
  logic [7:0] rd_value;
  logic rd_hit;
  logic wr_hit;
  logic wr_fire;
  logic [9:0] ar_idx;
  logic [2:0] run_lvl;
  logic [2:0] sleep_lvl;
  logic [2:0] act_lvl;
  logic [2:0] seg_code;
  scb_irq_t irq_en;
  logic pin_d_reg;
  logic pin_fall;
  logic presc_tick;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign wr_fire = aw_have_reg && w_have_reg && (wr_state_reg == SCB_WR_IDLE);

  always_comb begin
    unique case (wr_idx_reg)
      `SCB_IDX_SUPPLY, `SCB_IDX_IEM, `SCB_IDX_IEX,
      `SCB_IDX_ROSC, `SCB_IDX_PORT3, `SCB_IDX_LCD: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      aw_have_reg <= 1'b0;
      wr_idx_reg <= 10'h000;
      s_axi_awready_out <= 1'b1;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_have_reg <= 1'b1;
      wr_idx_reg <= s_axi_awaddr_in[11:2];
      s_axi_awready_out <= 1'b0;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_awready_out <= 1'b1;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      w_have_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      wr_lane_reg <= 1'b0;
      s_axi_wready_out <= 1'b1;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_have_reg <= 1'b1;
      wr_data_reg <= s_axi_wdata_in[7:0];
      wr_lane_reg <= s_axi_wstrb_in[0];
      s_axi_wready_out <= 1'b0;
    end else if (s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_wready_out <= 1'b1;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_state_reg <= SCB_WR_IDLE;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `SCB_RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        SCB_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= SCB_WR_RESP;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_hit ? `SCB_RESP_OKAY : `SCB_RESP_SLVERR;
          end
        end
        SCB_WR_RESP: begin
          if (s_axi_bready_in) begin
            wr_state_reg <= SCB_WR_IDLE;
            s_axi_bvalid_out <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage; only byte lane 0 carries data
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      supply_reg <= `SCB_RST_SUPPLY;
      iem_reg <= `SCB_RST_IEM;
      iex_reg <= `SCB_RST_IEX;
      rosc_reg <= `SCB_RST_ROSC;
      port3_reg <= `SCB_RST_PORT3;
      lcd_reg <= `SCB_RST_LCD;
    end else if (wr_fire && wr_lane_reg) begin
      unique case (wr_idx_reg)
        `SCB_IDX_SUPPLY: supply_reg <= wr_data_reg & `SCB_MASK_SUPPLY;
        `SCB_IDX_IEM: iem_reg <= wr_data_reg & `SCB_MASK_IEM;
        `SCB_IDX_IEX: iex_reg <= wr_data_reg & `SCB_MASK_IEX;
        `SCB_IDX_ROSC: rosc_reg <= wr_data_reg & `SCB_MASK_ROSC;
        `SCB_IDX_PORT3: port3_reg <= wr_data_reg & `SCB_MASK_PORT3;
        `SCB_IDX_LCD: lcd_reg <= wr_data_reg & `SCB_MASK_LCD;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle from address to data
  assign ar_idx = s_axi_araddr_in[11:2];

  always_comb begin
    rd_hit = 1'b1;
    unique case (ar_idx)
      `SCB_IDX_SUPPLY: rd_value = supply_reg;
      `SCB_IDX_IEM: rd_value = iem_reg;
      `SCB_IDX_IEX: rd_value = iex_reg;
      `SCB_IDX_ROSC: rd_value = rosc_reg;
      `SCB_IDX_PORT3: rd_value = port3_reg;
      `SCB_IDX_LCD: rd_value = lcd_reg;
      default: begin
        rd_value = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `SCB_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h00_0000, rd_value};
      s_axi_rresp_out <= rd_hit ? `SCB_RESP_OKAY : `SCB_RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply regulator level
  assign run_lvl = supply_reg[`SCB_RUN_LSB +: 3];
  assign sleep_lvl = supply_reg[`SCB_SLEEP_LSB +: 3];
  // idle and stop share the sleep level, so either mode flag selects it
  assign act_lvl = (sleep_mode_in || stop_mode_in) ? sleep_lvl : run_lvl;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      supply_save_select_out <= 1'b0;
      vdd_ratio_num_out <= `SCB_RATIO_FULL;
    end else begin
      supply_save_select_out <= supply_reg[`SCB_SAVE_BIT];
      if (supply_reg[`SCB_SAVE_BIT]) begin
        vdd_ratio_num_out <= `SCB_RATIO_BASE + `SCB_RATIO_STEP * {6'h00, act_lvl};
      end else begin
        vdd_ratio_num_out <= `SCB_RATIO_FULL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt gating and stop wake-up
  always_comb begin
    irq_en.timer3 = iex_reg[`SCB_T3_BIT];
    irq_en.port1 = iex_reg[`SCB_P1_BIT];
    irq_en.ext2 = iex_reg[`SCB_EX2_BIT];
    irq_en.timer2 = iem_reg[`SCB_T2_BIT];
    irq_en.uart = iem_reg[`SCB_UART_BIT];
    irq_en.timer1 = iem_reg[`SCB_T1_BIT];
    irq_en.ext1 = iem_reg[`SCB_EX1_BIT];
    irq_en.timer0 = iem_reg[`SCB_T0_BIT];
    irq_en.ext0 = iem_reg[`SCB_EX0_BIT];
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_req_out <= '0;
    end else if (iem_reg[`SCB_GATE_BIT]) begin
      irq_req_out <= irq_req_in & irq_en;
    end else begin
      irq_req_out <= '0;
    end
  end

  // wake-up follows the line's own enable only; the global gate stays out of it
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      stop_wake_out <= 1'b0;
    end else begin
      stop_wake_out <= stop_mode_in && ((ext_line_active_in.ext2 && irq_en.ext2) ||
                                        (ext_line_active_in.ext1 && irq_en.ext1) ||
                                        (ext_line_active_in.ext0 && irq_en.ext0));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer0 count source and resistor channel
  scb_prescaler #(
    .DIV_W(DIV_W)
  ) u_prescaler (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .rosc_tick_in(rosc_tick_in),
    .rosc_prescale_in(scb_psc_t'(rosc_reg[`SCB_PSC_LSB +: 2])),
    .div_tick_out(presc_tick)
  );

  assign pin_fall = pin_d_reg && !timer0_pin_in;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pin_d_reg <= 1'b0;
      timer0_count_tick_out <= 1'b0;
    end else begin
      pin_d_reg <= timer0_pin_in;
      if (!timer0_counter_mode_in) begin
        timer0_count_tick_out <= 1'b0;
      end else if (rosc_reg[`SCB_SRC_BIT]) begin
        timer0_count_tick_out <= presc_tick;
      end else begin
        timer0_count_tick_out <= pin_fall;
      end
    end
  end

  // code 11 is unassigned and connects no pin
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rosc_resistor_pin_out <= 3'h1;
    end else begin
      unique case (rosc_reg[`SCB_CHAN_LSB +: 2])
        2'h0: rosc_resistor_pin_out <= 3'h1;
        2'h1: rosc_resistor_pin_out <= 3'h2;
        2'h2: rosc_resistor_pin_out <= 3'h4;
        2'h3: rosc_resistor_pin_out <= 3'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lcd and port outputs
  assign seg_code = lcd_reg[`SCB_SEG_LSB +: 3];

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      display_on_out <= 1'b0;
      lcd_clock_source_out <= 1'b0;
      lcd_frame_rate_sel_out <= 2'h2;
      lcd_duty_select_out <= 1'b1;
      port0_segment_mask_out <= 8'hFF;
      port3_data_out <= `SCB_RST_PORT3;
    end else begin
      display_on_out <= lcd_reg[`SCB_DISP_BIT];
      lcd_clock_source_out <= lcd_reg[`SCB_LCD_CLOCK_SOURCE_BIT];
      lcd_frame_rate_sel_out <= lcd_reg[`SCB_FMR_LSB +: 2];
      lcd_duty_select_out <= lcd_reg[`SCB_DUTY_BIT];
      if (seg_code == 3'h0) begin
        port0_segment_mask_out <= 8'h00;
      end else begin
        port0_segment_mask_out <= ~(8'hFF >> ({1'b0, seg_code} + 4'h1));
      end
      port3_data_out <= port3_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_RUN_LEVEL: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (supply_reg[`SCB_SAVE_BIT] && !sleep_mode_in && !stop_mode_in)
      |=> vdd_ratio_num_out == `SCB_RATIO_BASE + `SCB_RATIO_STEP * {6'h00, $past(run_lvl)})
    else $error("run supply ratio wrong");

  AST_SAVE_OFF: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !supply_reg[`SCB_SAVE_BIT] |=> vdd_ratio_num_out == `SCB_RATIO_FULL)
    else $error("supply not equal to battery with save off");

  AST_SLEEP_LEVEL: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (supply_reg[`SCB_SAVE_BIT] && (sleep_mode_in || stop_mode_in))
      |=> vdd_ratio_num_out == `SCB_RATIO_BASE + `SCB_RATIO_STEP * {6'h00, $past(sleep_lvl)})
    else $error("sleep supply ratio wrong");

  AST_GATE_BLOCKS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !iem_reg[`SCB_GATE_BIT] |=> irq_req_out == '0)
    else $error("interrupt passed with global gate low");

  AST_TIMER2_PASS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (iem_reg[`SCB_GATE_BIT] && irq_req_in.timer2)
      |=> irq_req_out.timer2 == $past(iem_reg[`SCB_T2_BIT]))
    else $error("timer2 request not gated by its enable");

  AST_UART_PASS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (iem_reg[`SCB_GATE_BIT] && irq_req_in.uart) |=> irq_req_out.uart == $past(iem_reg[`SCB_UART_BIT]))
    else $error("uart request not gated by its enable");

  AST_LINE0_WAKE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (stop_mode_in && ext_line_active_in.ext0 && iem_reg[`SCB_EX0_BIT]) |=> stop_wake_out)
    else $error("line 0 wake-up missed");

  AST_LINE2_WAKE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (stop_mode_in && ext_line_active_in.ext2 && iex_reg[`SCB_EX2_BIT]) |=> stop_wake_out)
    else $error("line 2 wake-up missed");

  AST_PIN_SOURCE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (timer0_counter_mode_in && !rosc_reg[`SCB_SRC_BIT] && pin_fall) |=> timer0_count_tick_out)
    else $error("pin edge did not count");

  AST_SEG_ALL: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (seg_code == 3'h7) |=> port0_segment_mask_out == 8'hFF)
    else $error("code 7 did not select all segments");

  AST_RESERVED_ZERO: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (s_axi_arvalid_in && s_axi_arready_out && ar_idx == `SCB_IDX_IEM) |=> s_axi_rdata_out[6] == 1'b0)
    else $error("unassigned bit read as one");

endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import scb_pkg::*;
;
  localparam logic [11:0] A_SUP = 12'h29C;
  localparam logic [11:0] A_IEM = 12'h2A0;
  localparam logic [11:0] A_IEX = 12'h2A4;
  localparam logic [11:0] A_OSC = 12'h2BC;
  localparam logic [11:0] A_P3 = 12'h2C0;
  localparam logic [11:0] A_LCD = 12'h2C4;
  logic clk = 1'b0, rst = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic sleep_m = 1'b0, stop_m = 1'b0, t0_mode = 1'b1, t0_pin = 1'b1, rosc = 1'b0;
  scb_irq_t irq_in = 9'h1FF;
  scb_wake_t line = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, wake, tick, save, disp, lclk, duty;
  logic [1:0] bresp, rresp, frate;
  logic [31:0] rdata;
  scb_irq_t irq_out;
  logic [2:0] pin_sel;
  logic [8:0] ratio;
  logic [7:0] segm, p3;
  int fails = 0, comparisons = 0;
  // writable bits per register read back after an all-ones write
  logic [11:0] ra [4] = '{12'h29C, 12'h2A0, 12'h2A4, 12'h2BC};
  logic [7:0] rm [4] = '{8'h7F, 8'hBF, 8'h07, 8'h1F};
  logic [7:0] iem_t [4] = '{8'h3F, 8'hBF, 8'hA5, 8'h9A};
  logic [7:0] iex_t [4] = '{8'h07, 8'h07, 8'h02, 8'h05};
  logic [8:0] irq_t [4] = '{9'h000, 9'h1FF, 9'h0A5, 9'h15A};
  logic [7:0] wm [5] = '{8'h01, 8'h01, 8'h04, 8'h00, 8'h00};
  logic [7:0] wx [5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04};
  logic [2:0] wl [5] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  logic [4:0] wstop = 5'b01111, wexp = 5'b01101;

  scb_control_bank uut (.core_clk_in(clk), .sys_rst_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .sleep_mode_in(sleep_m), .stop_mode_in(stop_m), .irq_req_in(irq_in), .irq_req_out(irq_out),
    .ext_line_active_in(line), .stop_wake_out(wake), .timer0_counter_mode_in(t0_mode),
    .timer0_pin_in(t0_pin), .rosc_tick_in(rosc), .timer0_count_tick_out(tick),
    .rosc_resistor_pin_out(pin_sel), .supply_save_select_out(save), .vdd_ratio_num_out(ratio),
    .display_on_out(disp), .lcd_clock_source_out(lclk), .lcd_frame_rate_sel_out(frate),
    .lcd_duty_select_out(duty), .port0_segment_mask_out(segm), .port3_data_out(p3));

  initial begin
    forever #2 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // bus tasks hold each channel until its own ready is sampled
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) begin
      fails++;
      give_verdict();
    end
    chk(bresp, er);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 40) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, {24'h0, e});
    chk(r, 32'h0);
  endtask

  // outputs trail the register by one cycle, so let two edges pass
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rc(A_SUP, 8'h22);
    rc(A_IEM, 8'h00);
    rc(A_IEX, 8'h00);
    rc(A_OSC, 8'h0C);
    rc(A_P3, 8'hFF);
    rc(A_LCD, 8'h2F);
    chk({save, ratio}, 32'h12C);
    chk({disp, frate, duty, segm}, 32'h5FF);
    chk({irq_out, pin_sel}, 32'h1);
  endtask

  task automatic t_reserved;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      wr(ra[i], 8'hFF, 2'h0);
      rc(ra[i], rm[i]);
    end
    wr(12'h2A8, 8'h55, 2'h2);
    rd(12'h2A8, d, r);
    chk(d, 32'h0);
    chk(r, 32'h2);
  endtask

  task automatic t_supply;
    for (int c = 0; c < 8; c++) begin
      wr(A_SUP, 8'(8'h40 | (c << 3) | (7 - c)), 2'h0);
      sleep_m <= 1'b0;
      settle();
      chk({save, ratio}, 32'h200 | (115 + 11 * c));
      @(posedge clk);
      sleep_m <= 1'b1;
      settle();
      chk({save, ratio}, 32'h200 | (115 + 11 * (7 - c)));
    end
    wr(A_SUP, 8'h22, 2'h0);
    sleep_m <= 1'b0;
    settle();
    chk({save, ratio}, 32'h12C);
  endtask

  task automatic t_irq;
    for (int i = 0; i < 4; i++) begin
      wr(A_IEM, iem_t[i], 2'h0);
      wr(A_IEX, iex_t[i], 2'h0);
      settle();
      chk(irq_out, irq_t[i]);
    end
  endtask

  task automatic t_wake;
    for (int i = 0; i < 5; i++) begin
      wr(A_IEM, wm[i], 2'h0);
      wr(A_IEX, wx[i], 2'h0);
      line <= wl[i];
      stop_m <= wstop[i];
      settle();
      chk(wake, wexp[i]);
    end
  endtask

  task automatic t_timer0;
    int k;
    int n;
    wr(A_OSC, 8'h0C, 2'h0);
    rosc <= 1'b1;
    t0_pin <= 1'b0;
    n = 0;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      if (tick) n++;
    end
    rosc <= 1'b0;
    t0_pin <= 1'b1;
    chk(n, 1);
    for (int p = 0; p < 4; p++) begin
      wr(A_OSC, 8'(8'h10 | (p << 2) | (p % 3)), 2'h0);
      rosc <= 1'b1;
      n = 0;
      for (k = 0; k < 68; k++) begin
        @(posedge clk);
        if (tick) n++;
        if (k == 63) rosc <= 1'b0;
      end
      chk(n, 64 >> (2 * (3 - p)));
      chk(pin_sel, 1 << (p % 3));
    end
  endtask

  task automatic t_lcd;
    wr(A_LCD, 8'hF8, 2'h0);
    settle();
    chk({disp, lclk, frate, duty, segm}, 32'h1F00);
    wr(A_LCD, 8'h17, 2'h0);
    wr(A_P3, 8'h5A, 2'h0);
    settle();
    chk({disp, lclk, frate, duty, segm}, 32'h02FF);
    chk(p3, 32'h5A);
    rc(A_LCD, 8'h17);
    wr(A_LCD, 8'h01, 2'h0);
    settle();
    chk(segm, 32'hC0);
    wr(A_LCD, 8'h06, 2'h0);
    settle();
    chk(segm, 32'hFE);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_reserved();
    t_supply();
    t_irq();
    t_wake();
    t_timer0();
    t_lcd();
    give_verdict();
  end
endmodule
`default_nettype wire
